// ==== src/vatu_pkg.sv ====
// Constants, entry layouts and enumerations for the address translation unit.
// Assumes a 32-bit virtual and physical address and 4 kB pages.
package vatu_pkg;
  localparam int VA_W        = 32;
  localparam int PAGE_OFS_W  = 12;
  localparam int VPN_W       = 20;
  localparam int PID_W       = 6;
  localparam int HI_RSVD_W   = 6;
  localparam int LO_RSVD_W   = 8;
  localparam int ENTRIES     = 64;
  localparam int DIRECT_W    = 29;
  localparam int CTX_BASE_W  = 11;
  localparam int CTX_VPN_W   = 19;
  localparam int CTX_PAD_W   = 2;
  localparam int REV_W       = 16;
  localparam int SEG_SEL_W   = 3;

  // Top address bits that pick a kernel segment; user segment has bit 31 clear
  localparam logic [SEG_SEL_W-1:0] SEG_SEL_K0 = 3'h4;
  localparam logic [SEG_SEL_W-1:0] SEG_SEL_K1 = 3'h5;
  localparam logic [VA_W-DIRECT_W-1:0] DIRECT_FILL = 3'h0;
  localparam logic [CTX_PAD_W-1:0]     CTX_PAD     = 2'h0;
  localparam logic [CTX_BASE_W-1:0]    CTX_BASE_RST = 11'h000;
  localparam logic [VA_W-1:0]          VADDR_RST   = 32'h0000_0000;

  typedef struct packed {
    logic [VPN_W-1:0]     virtual_page_number;
    logic [PID_W-1:0]     process_identifier;
    logic [HI_RSVD_W-1:0] rsvd;
  } entry_hi_t;

  typedef struct packed {
    logic [VPN_W-1:0]     physical_frame_number;
    logic                 noncache;
    logic                 dirty;
    logic                 valid;
    logic                 global_map;
    logic [LO_RSVD_W-1:0] rsvd;
  } entry_lo_t;

  localparam entry_hi_t HI_RST = '0;
  localparam entry_lo_t LO_RST = '0;

  typedef enum logic [1:0] {
    SEG_USER, SEG_KERNEL_DIRECT_CACHED, SEG_KERNEL_DIRECT_UNCACHED, SEG_KERNEL_MAPPED
  } segment_t;

  typedef enum logic [2:0] {
    FAULT_NONE, FAULT_ADDRESS, FAULT_MISS, FAULT_INVALID, FAULT_MODIFIED
  } fault_t;

  typedef enum logic [2:0] {
    OP_READ_INDEXED, OP_WRITE_INDEXED, OP_WRITE_RANDOM, OP_PROBE, OP_RESTORE
  } entry_op_t;

  typedef struct packed {
    logic [VA_W-1:0] vaddr;
    logic            store;
  } xlat_req_t;

  typedef struct packed {
    logic [VA_W-1:0] paddr;
    logic            cached;
    fault_t          fault;
  } xlat_rsp_t;
endpackage : vatu_pkg

// ==== src/vatu_entry.sv ====
// One translation buffer slot: stored halves and two match comparators.
// Assumes the caller forces reserved bits to zero on write.
`timescale 1ns/1ps
module vatu_entry (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     wr_en,
  input  wire vatu_pkg::entry_hi_t      wr_hi,
  input  wire vatu_pkg::entry_lo_t      wr_lo,
  input  wire logic [vatu_pkg::VPN_W-1:0] xl_vpn,
  input  wire logic [vatu_pkg::PID_W-1:0] xl_pid,
  input  wire logic [vatu_pkg::VPN_W-1:0] pr_vpn,
  input  wire logic [vatu_pkg::PID_W-1:0] pr_pid,
  output vatu_pkg::entry_hi_t           hi,
  output vatu_pkg::entry_lo_t           lo,
  output logic                          xl_hit,
  output logic                          pr_hit
);
  import vatu_pkg::*;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi <= HI_RST;
      lo <= LO_RST;
    end else if (wr_en) begin
      hi <= wr_hi;
      lo <= wr_lo;
    end
  end

  // Global entries ignore the identifier; valid is judged by the caller
  assign xl_hit = (hi.virtual_page_number == xl_vpn) && (lo.global_map || hi.process_identifier == xl_pid); // [R2] [R3]
  assign pr_hit = (hi.virtual_page_number == pr_vpn) && (lo.global_map || hi.process_identifier == pr_pid); // [R6]
endmodule : vatu_entry

// ==== src/vatu_random.sv ====
// Replacement pointer that steps down every clock and wraps inside a window.
// Assumes software never relies on a particular sequence.
`timescale 1ns/1ps
module vatu_random #(
  parameter int W    = 6,
  parameter int HIGH = 63,
  parameter int LOW  = 0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  output logic [W-1:0]      ptr
);
  if (LOW >= HIGH || HIGH >= (1 << W) || LOW < 0) begin : g_bad_window
    $error("vatu_random: window does not fit");
  end

  // Free running, so its value depends on instruction timing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr <= W'(HIGH);
    end else if (ptr == W'(LOW)) begin
      ptr <= W'(HIGH);
    end else begin
      ptr <= ptr - 1'b1;
    end
  end
endmodule : vatu_random

// ==== src/vatu_top.sv ====
// Address translation unit: translation buffer, segment decode, mode and fault record.
// Assumes the pipeline issues one translation and at most one entry op per cycle.
// Operation
// [R1] 64 fully associative entries, 4 kB pages
// [R2] Compare identifier and 20-bit page against all
// [R3] Page match plus identifier or global substitutes frame
// [R4] Entry holds noncache, dirty, valid, global flags
// [R5] No hardware refill; miss reported, random slot
// [R6] Read, write indexed, write random, probe operations
// [R7] Two staging registers exchange entry halves
// [R8] Lower 2 GB for all, upper kernel only
// [R9] User addresses extended by 6-bit identifier
// [R10] User segment mapped, cached per page flag
// [R11] Kernel mode treats user segment like user
// [R12] First kernel segment direct, cached, low 512 MB
// [R13] Second kernel segment direct, uncached, same region
// [R14] Upper kernel segment mapped, cached per entry
// [R15] Exception enters kernel until restore op
// [R16] Record faulting address and page table pointer
// [R17] Revision register readable, never written
// [R18] Segments decoded from top address bits
// [R19] Mode, miss or write protect raise fault
`timescale 1ns/1ps
module vatu_top #(
  parameter int               ENTRIES    = vatu_pkg::ENTRIES,
  parameter int               RAND_LOW   = 0,
  parameter logic [15:0]      REVISION   = 16'h0a5c
) (
  input  wire logic                               clk,
  input  wire logic                               arst_n,
  input  wire logic                               xlat_req,
  input  wire vatu_pkg::xlat_req_t                xlat_in,
  output logic                                    xlat_done,
  output vatu_pkg::xlat_rsp_t                     xlat_out,
  input  wire logic                               op_valid,
  input  wire vatu_pkg::entry_op_t                op,
  input  wire logic                               exception_in,
  input  wire logic                               hi_wr,
  input  wire vatu_pkg::entry_hi_t                hi_wr_data,
  input  wire logic                               lo_wr,
  input  wire vatu_pkg::entry_lo_t                lo_wr_data,
  input  wire logic                               index_wr,
  input  wire logic [$clog2(ENTRIES)-1:0]         index_wr_data,
  input  wire logic                               ctx_wr,
  input  wire logic [vatu_pkg::CTX_BASE_W-1:0]    ctx_wr_base,
  output vatu_pkg::entry_hi_t                     entry_high_staging,
  output vatu_pkg::entry_lo_t                     entry_low_staging,
  output logic [$clog2(ENTRIES)-1:0]              index,
  output logic                                    probe_fail,
  output logic [$clog2(ENTRIES)-1:0]              random_ptr,
  output logic [vatu_pkg::VA_W-1:0]               faulting_virtual_address,
  output logic [vatu_pkg::VA_W-1:0]               context_ptr,
  output logic                                    kernel_mode,
  output logic [15:0]                             revision_identification
);
  import vatu_pkg::*;

  localparam int IDX_W = $clog2(ENTRIES);

  if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES) begin : g_bad_entries
    $error("vatu_top: ENTRIES must be a power of two");
  end

  entry_hi_t               hi_arr [ENTRIES];
  entry_lo_t               lo_arr [ENTRIES];
  logic [ENTRIES-1:0]      xl_hit;
  logic [ENTRIES-1:0]      pr_hit;
  logic [ENTRIES-1:0]      wr_sel;
  logic [IDX_W-1:0]        rnd;
  logic [IDX_W-1:0]        xl_idx;
  logic                    xl_any;
  logic [IDX_W-1:0]        pr_idx;
  logic                    pr_any;
  segment_t                seg;
  xlat_rsp_t               next_rsp;
  entry_hi_t               wr_hi;
  entry_lo_t               wr_lo;
  logic [CTX_BASE_W-1:0]   ctx_base;
  logic [CTX_VPN_W-1:0]    ctx_vpn;

  // Reserved bits are forced to zero on every store into an entry
  always_comb begin
    wr_hi      = entry_high_staging;
    wr_hi.rsvd = '0;
    wr_lo      = entry_low_staging;
    wr_lo.rsvd = '0; // [R4]
  end

  for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
    assign wr_sel[g] = op_valid &&
      ((op == OP_WRITE_INDEXED && index == IDX_W'(g)) ||
       (op == OP_WRITE_RANDOM && rnd == IDX_W'(g))); // [R6]
    vatu_entry u_entry ( // [R1]
      .clk    (clk),
      .arst_n (arst_n),
      .wr_en  (wr_sel[g]),
      .wr_hi  (wr_hi),
      .wr_lo  (wr_lo),
      .xl_vpn (xlat_in.vaddr[VA_W-1:PAGE_OFS_W]),
      .xl_pid (entry_high_staging.process_identifier), // [R9]
      .pr_vpn (entry_high_staging.virtual_page_number),
      .pr_pid (entry_high_staging.process_identifier),
      .hi     (hi_arr[g]),
      .lo     (lo_arr[g]),
      .xl_hit (xl_hit[g]),
      .pr_hit (pr_hit[g])
    );
  end

  vatu_random #(
    .W    (IDX_W),
    .HIGH (ENTRIES - 1),
    .LOW  (RAND_LOW)
  ) u_random (
    .clk    (clk),
    .arst_n (arst_n),
    .ptr    (rnd)
  ); // [R5]

  // Lowest numbered match wins; software must avoid duplicate mappings
  always_comb begin
    xl_idx = '0;
    xl_any = 1'b0;
    pr_idx = '0;
    pr_any = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (xl_hit[i]) begin
        xl_any = 1'b1;
        xl_idx = IDX_W'(i);
      end
      if (pr_hit[i]) begin
        pr_any = 1'b1;
        pr_idx = IDX_W'(i);
      end
    end
  end

  always_comb begin
    if (!xlat_in.vaddr[VA_W-1]) begin
      seg = SEG_USER; // [R8] [R18]
    end else if (xlat_in.vaddr[VA_W-1 -: SEG_SEL_W] == SEG_SEL_K0) begin
      seg = SEG_KERNEL_DIRECT_CACHED;
    end else if (xlat_in.vaddr[VA_W-1 -: SEG_SEL_W] == SEG_SEL_K1) begin
      seg = SEG_KERNEL_DIRECT_UNCACHED;
    end else begin
      seg = SEG_KERNEL_MAPPED;
    end
  end

  always_comb begin
    next_rsp.paddr  = '0;
    next_rsp.cached = 1'b0;
    next_rsp.fault  = FAULT_NONE;
    if (seg != SEG_USER && !kernel_mode) begin
      next_rsp.fault = FAULT_ADDRESS; // [R8] [R19]
    end else begin
      unique case (seg)
        SEG_KERNEL_DIRECT_CACHED: begin
          next_rsp.paddr  = {DIRECT_FILL, xlat_in.vaddr[DIRECT_W-1:0]}; // [R12]
          next_rsp.cached = 1'b1;
        end
        SEG_KERNEL_DIRECT_UNCACHED: begin
          next_rsp.paddr  = {DIRECT_FILL, xlat_in.vaddr[DIRECT_W-1:0]}; // [R13]
          next_rsp.cached = 1'b0;
        end
        SEG_USER, SEG_KERNEL_MAPPED: begin // [R10] [R11] [R14]
          if (!xl_any) begin
            next_rsp.fault = FAULT_MISS; // [R5] [R19]
          end else if (!lo_arr[xl_idx].valid) begin
            next_rsp.fault = FAULT_INVALID; // [R19]
          end else if (xlat_in.store && !lo_arr[xl_idx].dirty) begin
            next_rsp.fault = FAULT_MODIFIED; // [R4] [R19]
          end else begin
            next_rsp.paddr  = {lo_arr[xl_idx].physical_frame_number, xlat_in.vaddr[PAGE_OFS_W-1:0]}; // [R3]
            next_rsp.cached = !lo_arr[xl_idx].noncache; // [R10] [R14]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xlat_done <= 1'b0;
      xlat_out  <= '0;
    end else begin
      xlat_done <= xlat_req;
      if (xlat_req) begin
        xlat_out <= next_rsp;
      end
    end
  end

  // Faulting address and page table pointer follow the latest fault
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faulting_virtual_address <= VADDR_RST;
      ctx_vpn                  <= '0;
    end else if (xlat_req && next_rsp.fault != FAULT_NONE) begin
      faulting_virtual_address <= xlat_in.vaddr; // [R16]
      ctx_vpn                  <= xlat_in.vaddr[VA_W-2:PAGE_OFS_W]; // [R16]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx_base <= CTX_BASE_RST;
    end else if (ctx_wr) begin
      ctx_base <= ctx_wr_base;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      context_ptr <= '0;
    end else begin
      context_ptr <= {ctx_base, ctx_vpn, CTX_PAD};
    end
  end

  // A read op overrides a software write to the staging halves
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      entry_high_staging <= HI_RST;
      entry_low_staging  <= LO_RST;
    end else if (op_valid && op == OP_READ_INDEXED) begin
      entry_high_staging <= hi_arr[index]; // [R6] [R7]
      entry_low_staging  <= lo_arr[index]; // [R6] [R7]
    end else begin
      if (hi_wr) begin
        entry_high_staging      <= hi_wr_data; // [R7]
        entry_high_staging.rsvd <= '0;
      end
      if (lo_wr) begin
        entry_low_staging      <= lo_wr_data; // [R7]
        entry_low_staging.rsvd <= '0;
      end
    end
  end

  // A probe result overrides a software write to the index
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      index      <= '0;
      probe_fail <= 1'b0;
    end else if (op_valid && op == OP_PROBE) begin
      probe_fail <= !pr_any; // [R6]
      if (pr_any) begin
        index <= pr_idx;
      end
    end else if (index_wr) begin
      index      <= index_wr_data;
      probe_fail <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      random_ptr <= '0;
    end else begin
      random_ptr <= rnd;
    end
  end

  // Reset counts as an exception; an exception beats a same-cycle restore
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kernel_mode <= 1'b1;
    end else if (exception_in) begin
      kernel_mode <= 1'b1; // [R15]
    end else if (op_valid && op == OP_RESTORE) begin
      kernel_mode <= 1'b0; // [R15]
    end
  end

  // No write path exists, so writes cannot reach it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      revision_identification <= REVISION; // [R17]
    end
  end

  a_user_kernel_fault: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
    xlat_req && !kernel_mode && xlat_in.vaddr[VA_W-1]
      |=> xlat_done && xlat_out.fault == FAULT_ADDRESS)
    else $error("user access to kernel segment not faulted");

  a_direct_cached_map: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
    xlat_req && kernel_mode && xlat_in.vaddr[VA_W-1 -: SEG_SEL_W] == SEG_SEL_K0
      |=> xlat_out.cached && xlat_out.fault == FAULT_NONE &&
          xlat_out.paddr == {DIRECT_FILL, $past(xlat_in.vaddr[DIRECT_W-1:0])})
    else $error("cached direct segment mapped wrongly");

  a_direct_uncached_map: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
    xlat_req && kernel_mode && xlat_in.vaddr[VA_W-1 -: SEG_SEL_W] == SEG_SEL_K1
      |=> !xlat_out.cached &&
          xlat_out.paddr == {DIRECT_FILL, $past(xlat_in.vaddr[DIRECT_W-1:0])})
    else $error("uncached direct segment mapped wrongly");

  a_mapped_offset_kept: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
    xlat_req && !xlat_in.vaddr[VA_W-1]
      ##1 xlat_out.fault == FAULT_NONE
      |-> xlat_out.paddr[PAGE_OFS_W-1:0] == $past(xlat_in.vaddr[PAGE_OFS_W-1:0]))
    else $error("page offset not carried through");

  a_fault_recorded: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
    xlat_req ##1 xlat_out.fault != FAULT_NONE
      |-> faulting_virtual_address == $past(xlat_in.vaddr) &&
          ctx_vpn == $past(xlat_in.vaddr[VA_W-2:PAGE_OFS_W]))
    else $error("faulting address not recorded");

  a_exception_kernel: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
    exception_in |=> kernel_mode)
    else $error("exception did not enter kernel mode");

  a_mode_holds: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
    kernel_mode && !(op_valid && op == OP_RESTORE) |=> kernel_mode)
    else $error("kernel mode left without restore");

  a_restore_user: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
    op_valid && op == OP_RESTORE && !exception_in |=> !kernel_mode)
    else $error("restore did not return to user mode");

  a_revision_stable: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
    revision_identification == REVISION)
    else $error("revision register changed");

  a_probe_miss_flag: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
    op_valid && op == OP_PROBE && pr_hit == '0 |=> probe_fail && $stable(index))
    else $error("probe miss not flagged");

  a_store_protect: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
    xlat_req && xlat_in.store && !xlat_in.vaddr[VA_W-1] && xl_any &&
      lo_arr[xl_idx].valid && !lo_arr[xl_idx].dirty
      |=> xlat_out.fault == FAULT_MODIFIED)
    else $error("store to protected page not faulted");

  a_mapped_cache_flag: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
    xlat_req && (seg == SEG_USER || (seg == SEG_KERNEL_MAPPED && kernel_mode)) && xl_any &&
      lo_arr[xl_idx].valid && (!xlat_in.store || lo_arr[xl_idx].dirty)
      |=> xlat_out.cached == !$past(lo_arr[xl_idx].noncache))
    else $error("mapped cacheability not taken from entry");

  a_probe_hit_index: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
    op_valid && op == OP_PROBE && pr_hit != '0
      |=> !probe_fail && hi_arr[index].virtual_page_number == $past(entry_high_staging.virtual_page_number))
    else $error("probe hit did not point at matching entry");
endmodule : vatu_top

// ==== sim/pipe_model.sv ====
// Pipeline side model: issues virtual addresses toward the translation unit.
// Assumes the bench raises issue after a falling edge and holds it one cycle per request.
`timescale 1ns/1ps
module pipe_model (
  input  wire logic           clk,
  input  wire logic           issue,
  input  wire logic [31:0]    issue_vaddr,
  input  wire logic           issue_store,
  output logic                xlat_req,
  output vatu_pkg::xlat_req_t xlat_in
);
  import vatu_pkg::*;
  xlat_req_t idle_pat = '0;
  // Lines churn between requests so a stale address never passes for a real one
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign xlat_req = issue;
  assign xlat_in  = issue ? xlat_req_t'{issue_vaddr, issue_store} : idle_pat;
endmodule : pipe_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the translation unit with a response scoreboard.
// Assumes vatu_pkg and the design sources are compiled first.
`timescale 1ns/1ps
module tb_top;
  import vatu_pkg::*;
  logic                clk = 0;
  logic                arst_n = 0;
  logic                issue = 0, ist = 0, xlat_req, xlat_done;
  logic [31:0]         iva = '0, fva, ctxp;
  xlat_req_t           xlat_in;
  xlat_rsp_t           xlat_out;
  xlat_rsp_t           exp_q[$];
  logic                op_valid = 0, exception_in = 0, hi_wr = 0, lo_wr = 0;
  logic                index_wr = 0, ctx_wr = 0, probe_fail, kernel_mode;
  entry_op_t           op = OP_READ_INDEXED;
  entry_hi_t           hi_wr_data = '0, ehs;
  entry_lo_t           lo_wr_data = '0, els;
  logic [5:0]          index_wr_data = '0, index, random_ptr, rp;
  logic [10:0]         ctx_wr_base = '0;
  logic [15:0]         rev, s;
  logic [31:0]         va;
  int                  mismatches = 0, samples_checked = 0, cycles = 0, edges = 0;

  initial forever #5 clk = ~clk;

  pipe_model u_pipe (.clk(clk), .issue(issue), .issue_vaddr(iva), .issue_store(ist),
    .xlat_req(xlat_req), .xlat_in(xlat_in));

  vatu_top u_dut (.clk(clk), .arst_n(arst_n), .xlat_req(xlat_req), .xlat_in(xlat_in),
    .xlat_done(xlat_done), .xlat_out(xlat_out), .op_valid(op_valid), .op(op),
    .exception_in(exception_in), .hi_wr(hi_wr), .hi_wr_data(hi_wr_data), .lo_wr(lo_wr),
    .lo_wr_data(lo_wr_data), .index_wr(index_wr), .index_wr_data(index_wr_data),
    .ctx_wr(ctx_wr), .ctx_wr_base(ctx_wr_base), .entry_high_staging(ehs),
    .entry_low_staging(els), .index(index), .probe_fail(probe_fail),
    .random_ptr(random_ptr), .faulting_virtual_address(fva), .context_ptr(ctxp),
    .kernel_mode(kernel_mode), .revision_identification(rev));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Leaves issue high unless last, so successive calls run back to back
  task automatic xl(input logic [31:0] v, input logic st, input logic [31:0] pa,
                    input logic c, input fault_t f, input logic last);
    @(negedge clk);
    issue = 1;
    iva = v;
    ist = st;
    exp_q.push_back(xlat_rsp_t'{pa, c, f});
    if (last) begin
      @(negedge clk);
      issue = 0;
    end
  endtask : xl

  task automatic do_op(input entry_op_t o);
    @(negedge clk);
    op_valid = 1;
    op = o;
    @(negedge clk);
    op_valid = 0;
  endtask : do_op

  task automatic stage(input entry_hi_t h, input entry_lo_t l, input logic [5:0] ix);
    @(negedge clk);
    hi_wr = 1;
    hi_wr_data = h;
    lo_wr = 1;
    lo_wr_data = l;
    index_wr = 1;
    index_wr_data = ix;
    @(negedge clk);
    hi_wr = 0;
    lo_wr = 0;
    index_wr = 0;
  endtask : stage

  always @(posedge clk) begin
    #1;
    if (xlat_done === 1'b1) begin
      if (exp_q.size() == 0) check("xlat_done", 64'(xlat_done), 64'h0);
      else check("xlat_out", 64'(xlat_out), 64'(exp_q.pop_front()));
    end
  end

  // Ceiling well above the hundred or so cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (arst_n) edges++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    arst_n = 1;
    check("kernel_mode", 64'(kernel_mode), 64'h1);
    check("revision", 64'(rev), 64'h0a5c);
    @(negedge clk);
    ctx_wr = 1;
    ctx_wr_base = 11'h2a5;
    @(negedge clk);
    ctx_wr = 0;
    stage('{20'h00400, 6'h05, 6'h3f}, '{20'h12345, 1'b0, 1'b1, 1'b1, 1'b0, 8'hff}, 6'h03);
    check("staging_hi", 64'(ehs), 64'h0040_0140);
    do_op(OP_WRITE_INDEXED);
    stage('{20'hc0001, 6'h02, 6'h00}, '{20'h00abc, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00}, 6'h07);
    do_op(OP_WRITE_INDEXED);
    stage('0, '0, 6'h03);
    do_op(OP_READ_INDEXED);
    check("staging_hi", 64'(ehs), 64'h0040_0140);
    check("staging_lo", 64'(els), 64'h1234_5600);
    xl(32'h0040_0abc, 1'b0, 32'h1234_5abc, 1'b1, FAULT_NONE, 1'b0);
    xl(32'h8000_1234, 1'b1, 32'h0000_1234, 1'b1, FAULT_NONE, 1'b0);
    xl(32'ha000_1234, 1'b0, 32'h0000_1234, 1'b0, FAULT_NONE, 1'b0);
    xl(32'hc000_1010, 1'b0, 32'h00ab_c010, 1'b0, FAULT_NONE, 1'b0);
    xl(32'hc000_1010, 1'b1, 32'h0, 1'b0, FAULT_MODIFIED, 1'b0);
    xl(32'hc000_2ff0, 1'b0, 32'h0, 1'b0, FAULT_MISS, 1'b1);
    @(negedge clk);
    check("faulting_va", 64'(fva), 64'hc000_2ff0);
    @(negedge clk);
    check("context_ptr", 64'(ctxp), 64'({11'h2a5, 19'h40002, 2'h0}));
    stage('{20'h00400, 6'h06, 6'h00}, '0, 6'h03);
    xl(32'h0040_0abc, 1'b0, 32'h0, 1'b0, FAULT_MISS, 1'b1);
    // Entry present but not valid must not translate
    stage('{20'h00888, 6'h06, 6'h00}, '{20'h00066, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00}, 6'h05);
    do_op(OP_WRITE_INDEXED);
    xl(32'h0088_8123, 1'b0, 32'h0, 1'b0, FAULT_INVALID, 1'b1);
    stage('{20'h12345, 6'h05, 6'h00}, '0, 6'h03);
    do_op(OP_PROBE);
    check("probe_fail", 64'(probe_fail), 64'h1);
    check("index", 64'(index), 64'h3);
    stage('{20'h00400, 6'h05, 6'h00}, '0, 6'h00);
    do_op(OP_PROBE);
    check("probe_fail", 64'(probe_fail), 64'h0);
    check("index", 64'(index), 64'h3);
    stage('{20'h00777, 6'h09, 6'h00}, '{20'h00055, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00}, 6'h00);
    do_op(OP_WRITE_RANDOM);
    // Pointer counts down from the top slot once per edge since reset
    check("random_ptr", 64'(random_ptr), 64'(6'(0 - edges)));
    rp = random_ptr;
    stage('{20'h00777, 6'h00, 6'h00}, '0, 6'h00);
    do_op(OP_PROBE);
    check("random_slot", 64'(index), 64'(rp));
    s = 16'd53;
    for (int i = 0; i < 24; i++) begin
      s = lfsr(s);
      va = {3'h4, s[12:0], s};
      xl(va, s[0], {3'h0, va[28:0]}, 1'b1, FAULT_NONE, i == 23);
    end
    do_op(OP_RESTORE);
    check("kernel_mode", 64'(kernel_mode), 64'h0);
    xl(32'h8000_0000, 1'b0, 32'h0, 1'b0, FAULT_ADDRESS, 1'b0);
    xl(32'ha000_0040, 1'b1, 32'h0, 1'b0, FAULT_ADDRESS, 1'b0);
    xl(32'h0077_7001, 1'b1, 32'h0005_5001, 1'b1, FAULT_NONE, 1'b1);
    @(negedge clk);
    exception_in = 1;
    op_valid = 1;
    op = OP_RESTORE;
    @(negedge clk);
    exception_in = 0;
    op_valid = 0;
    check("kernel_mode", 64'(kernel_mode), 64'h1);
    repeat (3) @(negedge clk);
    check("pending", 64'(exp_q.size()), 64'h0);
    give_verdict();
  end
endmodule : tb_top
